// ==== hw/pbd_pkg.sv ====
/*
 * Package for the page branch decoder: opcode fields, page numbers,
 * program counter widths and reset values.
 * Assumes 10-bit instruction words and a 4-bit core.
 */
package pbd_pkg;

    // Instruction and program counter widths
    localparam int WORD_W = 10;
    localparam int PAGE_W = 6;
    localparam int OFFS_W = 7;
    localparam int STK_W = PAGE_W + OFFS_W;

    // Fixed-address long branch, first word
    localparam logic [4:0] LONG_FIXED_OP = 5'h07;
    localparam int OP_HI = 9;
    localparam int OP_LO = 5;
    // Indexed long branch, first word
    localparam logic [9:0] LONG_INDEXED_OP = 10'h010;
    // Short page-two call: top three bits 011 carry an offset
    localparam logic [2:0] SHORT_CALL_OP = 3'h3;
    localparam int SHORT_OP_LO = 7;
    localparam logic [PAGE_W-1:0] CALL_PAGE = 6'h02;
    // Second word marker 10 in bits 9..8
    localparam logic [1:0] SECOND_MARK = 2'h2;

    // Reset values
    localparam logic [PAGE_W-1:0] PAGE_RST = 6'h00;
    localparam logic [OFFS_W-1:0] OFFS_RST = 7'h00;

    // Decoder states
    typedef enum logic [1:0] {
        PBD_FETCH,
        PBD_FIXED2,
        PBD_INDEXED2
    } pbd_state_e;

endpackage : pbd_pkg

// ==== hw/pbd_pc_step.sv ====
/*
 * Sequential program counter step: offset wraps within its page.
 * Assumes the offset width of the package.
 */
module pbd_pc_step
    import pbd_pkg::*;
(
    // Current offset
    input wire logic [pbd_pkg::OFFS_W-1:0] offsIn,
    // Next offset
    output logic [pbd_pkg::OFFS_W-1:0] offsOut
);

    // Increment within the page
    assign offsOut = offsIn + 7'h01;

endmodule : pbd_pc_step

// ==== hw/pbd_page_branch_decoder.sv ====
/*
 * Page branch decoder: executes the two long branches and the short
 * page-two call, updating the page and offset parts of the program
 * counter; other words just advance the counter.
 * A malformed second word still branches and pulses badSecond, so the
 * core may trap it later without stalling the fetch. A short call
 * offers a return address and a push strobe; the stack lives outside.
 * Assumes program memory presents one instruction word each cycle,
 * addressed by the counter outputs, and that the core supplies the
 * index and accumulator registers, settled in the second-word cycle.
 * The page range is not limited here: every page number is taken as
 * it stands, whatever the size of the program memory behind it.
 */

module pbd_page_branch_decoder
    import pbd_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Instruction word from program memory
    input wire logic [pbd_pkg::WORD_W-1:0] instrWord,
    // Core registers used by the indexed branch
    input wire logic [3:0] accumulator,
    input wire logic [2:0] indexReg,
    // Program counter
    output logic [pbd_pkg::PAGE_W-1:0] pcPagePart,
    output logic [pbd_pkg::OFFS_W-1:0] pcOffsetPart,
    // Return address for the stack on a call
    output logic [pbd_pkg::STK_W-1:0] returnAddr,
    output logic pushReturn,
    // High during the second word of a long branch
    output logic secondWord,
    // Second word lacked the 10 marker, or indexed second word had filler bits set
    output logic badSecond
);

    ////////////////////////////////////////////////////////////////////
    // All decoder state, registered as one word
    typedef struct packed {
        pbd_state_e state; // Fetch or which second word
        logic second; // Registered copy of state != fetch
        logic [PAGE_W-1:0] page;
        logic [OFFS_W-1:0] offs;
        logic [4:0] pageLow; // p4..p0 kept from the first word
        logic [STK_W-1:0] retAddr;
        logic push;
        logic bad;
    } pbd_regs_s;

    pbd_regs_s cur_r;
    pbd_regs_s cur_nxt;

    // Offset of the next word in sequence
    logic [OFFS_W-1:0] offsInc;

    // First-word decodes of the current word
    logic fixedFirst;
    logic indexedFirst;
    logic shortCall;

    ////////////////////////////////////////////////////////////////////
    // Opcode and operand decodes

    // First word of the fixed-address long branch
    function automatic logic isFixedFirst(
        input logic [WORD_W-1:0] word
    );
        return word[OP_HI:OP_LO] == LONG_FIXED_OP;
    endfunction : isFixedFirst

    // First word of the indexed long branch
    function automatic logic isIndexedFirst(
        input logic [WORD_W-1:0] word
    );
        return word == LONG_INDEXED_OP;
    endfunction : isIndexedFirst

    // One-word call into page two
    function automatic logic isShortCall(
        input logic [WORD_W-1:0] word
    );
        return word[WORD_W-1:SHORT_OP_LO] == SHORT_CALL_OP;
    endfunction : isShortCall

    // Second word without the 10 marker
    function automatic logic markMissing(
        input logic [WORD_W-1:0] word
    );
        return word[9:8] != SECOND_MARK;
    endfunction : markMissing

    // Indexed second word with nonzero filler bits
    function automatic logic fillerSet(
        input logic [WORD_W-1:0] word
    );
        return word[5:4] != 2'h0;
    endfunction : fillerSet

    // Page of the fixed branch: p5 joins the kept p4..p0
    function automatic logic [PAGE_W-1:0] fixedPage(
        input logic [WORD_W-1:0] word,
        input logic [4:0] lowBits
    );
        return {word[7], lowBits};
    endfunction : fixedPage

    // Page of the indexed branch: p5 p4 above p3..p0
    function automatic logic [PAGE_W-1:0] indexedPage(
        input logic [WORD_W-1:0] word
    );
        return {word[7:6], word[3:0]};
    endfunction : indexedPage

    // Offset of the indexed branch: index above accumulator
    function automatic logic [OFFS_W-1:0] indexedOffset(
        input logic [2:0] idx,
        input logic [3:0] acc
    );
        return {idx, acc};
    endfunction : indexedOffset

    // Stack word from page and offset
    function automatic logic [STK_W-1:0] packAddr(
        input logic [PAGE_W-1:0] page,
        input logic [OFFS_W-1:0] offs
    );
        return {page, offs};
    endfunction : packAddr

    ////////////////////////////////////////////////////////////////////
    // First-word decodes, acted on only in the fetch state
    assign fixedFirst = isFixedFirst(instrWord);
    assign indexedFirst = isIndexedFirst(instrWord);
    assign shortCall = isShortCall(instrWord);

    ////////////////////////////////////////////////////////////////////
    // Sequential step of the offset
    pbd_pc_step u_step (
        .offsIn(cur_r.offs),
        .offsOut(offsInc)
    );

    ////////////////////////////////////////////////////////////////////
    // Decode and next state
    always_comb begin
        // Defaults: hold, pulses low, offset steps
        cur_nxt = cur_r;
        cur_nxt.push = 1'b0;
        cur_nxt.bad = 1'b0;
        cur_nxt.offs = offsInc;
        unique case (cur_r.state)
            // Fetch: look for a first word
            PBD_FETCH: begin
                if (fixedFirst) begin
                    // Keep p4..p0 for the second word
                    cur_nxt.pageLow = instrWord[4:0];
                    cur_nxt.state = PBD_FIXED2;
                end else if (indexedFirst) begin
                    cur_nxt.state = PBD_INDEXED2;
                end else if (shortCall) begin
                    // Return to the word after the call
                    cur_nxt.retAddr = packAddr(cur_r.page, offsInc);
                    cur_nxt.push = 1'b1;
                    cur_nxt.page = CALL_PAGE;
                    cur_nxt.offs = instrWord[OFFS_W-1:0];
                end
            end
            // Second word of the fixed branch
            PBD_FIXED2: begin
                cur_nxt.state = PBD_FETCH;
                cur_nxt.bad = markMissing(instrWord);
                // Page p5..p0, offset a6..a0
                cur_nxt.page = fixedPage(instrWord, cur_r.pageLow);
                cur_nxt.offs = instrWord[OFFS_W-1:0];
            end
            // Second word of the indexed branch
            PBD_INDEXED2: begin
                cur_nxt.state = PBD_FETCH;
                cur_nxt.bad = markMissing(instrWord) ||
                              fillerSet(instrWord);
                // Page from p5 p4 and p3..p0
                cur_nxt.page = indexedPage(instrWord);
                // Offset from index above accumulator
                cur_nxt.offs = indexedOffset(indexReg, accumulator);
            end
            // Unused state code falls back to fetch
            default: begin
                cur_nxt.state = PBD_FETCH;
            end
        endcase
        // Registered copy for the secondWord port
        cur_nxt.second = (cur_nxt.state != PBD_FETCH);
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            cur_r.state <= PBD_FETCH;
            cur_r.second <= 1'b0;
            cur_r.page <= PAGE_RST;
            cur_r.offs <= OFFS_RST;
            cur_r.pageLow <= PAGE_RST[4:0];
            cur_r.retAddr <= {PAGE_RST, OFFS_RST};
            cur_r.push <= 1'b0;
            cur_r.bad <= 1'b0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign pcPagePart = cur_r.page;
    assign pcOffsetPart = cur_r.offs;
    assign returnAddr = cur_r.retAddr;
    assign pushReturn = cur_r.push;
    assign secondWord = cur_r.second;
    assign badSecond = cur_r.bad;

endmodule : pbd_page_branch_decoder

// ==== dv/pbd_asserts.sv ====
/* Port checker for the page branch decoder.
   Bound to the decoder from the bench top. */
module pbd_asserts
    import pbd_pkg::*;
(
    // Clock, reset, inputs
    input wire logic clock,
    input wire logic srst,
    input wire logic [pbd_pkg::WORD_W-1:0] instrWord,
    input wire logic [3:0] accumulator,
    input wire logic [2:0] indexReg,
    // Outputs
    input wire logic [pbd_pkg::PAGE_W-1:0] pcPagePart,
    input wire logic [pbd_pkg::OFFS_W-1:0] pcOffsetPart,
    input wire logic [pbd_pkg::STK_W-1:0] returnAddr,
    input wire logic pushReturn,
    input wire logic secondWord,
    input wire logic badSecond
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // First-word decodes
    wire fixW = !secondWord && instrWord[9:5] == LONG_FIXED_OP;
    wire idxW = !secondWord && instrWord == LONG_INDEXED_OP;
    wire callW = !secondWord && instrWord[9:7] == SHORT_CALL_OP;
    a_fixed_first: assert property (fixW |=> secondWord
        && pcOffsetPart == $past(pcOffsetPart) + 7'h01) else $error("fixed");
    a_fixed_load: assert property (fixW ##1 1 |=> pcPagePart ==
        {$past(instrWord[7]), $past(instrWord[4:0], 2)}
        && pcOffsetPart == $past(instrWord[6:0])) else $error("fixed load");
    a_indexed_load: assert property (idxW ##1 1 |=> pcOffsetPart ==
        {$past(indexReg), $past(accumulator)} && pcPagePart ==
        {$past(instrWord[7:6]), $past(instrWord[3:0])}) else $error("idx");
    a_indexed_two: assert property (idxW |=> secondWord ##1 !secondWord)
        else $error("idx words");
    a_short_call: assert property (callW |=> pcPagePart == CALL_PAGE
        && pcOffsetPart == $past(instrWord[6:0]) && pushReturn && !secondWord
        && returnAddr == {$past(pcPagePart), $past(pcOffsetPart) + 7'h01})
        else $error("call");
    c_fixed: cover property (fixW ##1 1);
    c_indexed: cover property (idxW ##1 1);
    c_calls: cover property (callW ##1 callW);
endmodule : pbd_asserts

// ==== dv/tb.sv ====
/* Random bench for the page branch decoder.
   Assumes the checker is compiled before it. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pbd_pkg::*;
    logic clock = '0, srst = '1, eSec = '0, ePush = '0, eBad = '0;
    logic [9:0] instrWord = '0, w1 = '0;
    logic [3:0] accumulator = '0;
    logic [2:0] indexReg = '0;
    logic [5:0] pcPagePart, ePg = '0;
    logic [6:0] pcOffsetPart, eOf = '0;
    logic [12:0] returnAddr, eRet = '0;
    logic pushReturn, secondWord, badSecond;
    logic [31:0] rnd;
    logic [9:0] q[$] = '{10'h0FF, 10'h3FF, 10'h010, 10'h2CF, 10'h1FF,
        10'h180, 10'h010, 10'h230};
    int fail_count = 0, checks = 0, k;
    wire [31:0] outs = {3'h0, pcPagePart, pcOffsetPart, returnAddr,
        pushReturn, secondWord, badSecond};
    wire [31:0] exps = {3'h0, ePg, eOf, eRet, ePush, eSec, eBad};
    pbd_page_branch_decoder u_dut (.clock, .srst, .instrWord, .accumulator,
        .indexReg, .pcPagePart, .pcOffsetPart, .returnAddr, .pushReturn,
        .secondWord, .badSecond);
    ////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial forever #2 clock = ~clock;
    initial begin
        #20000 fail_count++;
        finish_test();
    end
    // Target of a long branch second word
    function automatic logic [12:0] target(input logic [9:0] a, b);
        if (a == LONG_INDEXED_OP) return {b[7:6], b[3:0], indexReg, accumulator};
        return {b[7], a[4:0], b[6:0]};
    endfunction : target
    task check(input string n, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
            fail_count++;
        end
    endtask : check
    task finish_test();
        $display("fails %0d checks %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    // Corner words first, then biased random words
    initial begin
        void'($urandom(32'hCF77462F));
        repeat (3) @(posedge clock);
        for (int i = 0; i < 2000; i++) begin
            @(negedge clock);
            // One mid-run reset; outputs must return to reset values
            srst = (i == 1000);
            check("outputs", outs, exps);
            if (srst) begin
                {ePg, eOf, eRet, ePush, eSec, eBad} = '0;
                continue;
            end
            rnd = $urandom;
            {accumulator, indexReg, instrWord} = rnd[16:0];
            k = $urandom % 4;
            if (eSec && k != 3) instrWord[9:8] = SECOND_MARK;
            else if (k == 0) instrWord[9:5] = LONG_FIXED_OP;
            else if (k == 1) instrWord = LONG_INDEXED_OP;
            if (q.size() > 0) instrWord = q.pop_front();
            eBad = eSec && (instrWord[9:8] != SECOND_MARK
                || (w1 == LONG_INDEXED_OP && instrWord[5:4] != 2'h0));
            ePush = 0;
            if (eSec) begin
                {ePg, eOf} = target(w1, instrWord);
                eSec = 0;
            end else if (instrWord[9:7] == SHORT_CALL_OP) begin
                eRet = {ePg, eOf + 7'h01};
                {ePg, eOf, ePush} = {CALL_PAGE, instrWord[6:0], 1'b1};
            end else begin
                eOf++;
                w1 = instrWord;
                eSec = w1[9:5] == LONG_FIXED_OP || w1 == LONG_INDEXED_OP;
            end
        end
        // Last word of the run is checked too
        @(negedge clock);
        check("outputs", outs, exps);
        finish_test();
    end
endmodule : tb
bind pbd_page_branch_decoder pbd_asserts u_chk (.clock, .srst, .instrWord,
    .accumulator, .indexReg, .pcPagePart, .pcOffsetPart, .returnAddr,
    .pushReturn, .secondWord, .badSecond);
